//--- shared/ref_select_pkg.sv
// constants for the reference choice / holdover pin control block
// assumes a single 250 MHz core clock
`default_nettype none
package ref_select_pkg;
  localparam logic [0:0] REF_FIRST  = 1'h0;   // low level picks the first reference input
  localparam logic [0:0] REF_SECOND = 1'h1;   // high level picks the second reference input
  localparam logic [0:0] HOLD_OFF   = 1'h0;
  localparam logic [0:0] HOLD_ON    = 1'h1;
  localparam int         SYNC_STAGES = 2;
  localparam logic [0:0] PIN_RESET_VAL = 1'h0;
  localparam logic [0:0] DRIVE_OFF     = 1'h0;   // pad driver released, pin is an input
  localparam logic [0:0] DRIVE_ON      = 1'h1;   // pad driver enabled, pin is an output
  localparam logic [0:0] PDN_IDLE      = 1'h0;
  localparam logic [0:0] CORE_RST_ON   = 1'h1;
  localparam logic [0:0] CORE_RST_OFF  = 1'h0;
  localparam int         PIN_COUNT      = 4;     // pins passing the synchroniser
  localparam int         PIN_IDX_REF    = 0;     // bit positions in the synchronised group
  localparam int         PIN_IDX_HOLD   = 1;
  localparam int         PIN_IDX_PWROFF = 2;
  localparam int         PIN_IDX_RST    = 3;

  typedef enum logic [2:0] {
    ST_RESET   = 3'h1,
    ST_RUN     = 3'h2,
    ST_POWEROFF = 3'h4
  } op_state_e;
endpackage
`default_nettype wire

//--- design/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pin levels
// assumes the core clock and a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,   // core clock
  input  wire logic             rst_i,   // synchronous reset
  input  wire logic [WIDTH-1:0] async_i, // raw pin levels
  output logic      [WIDTH-1:0] sync_o   // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule
`default_nettype wire

//--- design/ref_select_holdover_pins.sv
// pin-level control of reference choice, holdover, power-off and chip reset
// assumes pins arrive asynchronously; the pad ring resolves in/out/oe triples
//
// Notes on behaviour
// - manual reference mode: pin is input, sampled
// - automatic reference mode: pin driven with active reference
// - low level means first reference input
// - high level means second reference input
// - manual holdover: high input forces holdover
// - automatic holdover: pin driven high in holdover
// - power-off request high keeps device powered down
// - reset pin high holds all logic reset except the pin synchroniser, which only rst_i resets
`timescale 1ns/10ps
`default_nettype none
module ref_select_holdover_pins (
  input  wire logic core_clk_i,            // core clock, 250 MHz
  input  wire logic rst_i,                 // on-chip power-on reset, synchronous, high
  input  wire logic ref_auto_mode_i,       // 1 = automatic reference switchover
  input  wire logic hold_auto_mode_i,      // 1 = automatic holdover
  input  wire logic auto_ref_choice_i,     // reference picked by switchover logic
  input  wire logic auto_holdover_i,       // holdover demanded by loss-of-reference logic
  input  wire logic reference_choice_pin_i,   // reference choice pin, input level
  output logic      reference_choice_pin_o,   // reference choice pin, driven level
  output logic      reference_choice_pin_oe_o,// reference choice pin, drive enable
  input  wire logic holdover_pin_i,        // holdover pin, input level
  output logic      holdover_pin_o,        // holdover pin, driven level
  output logic      holdover_pin_oe_o,     // holdover pin, drive enable
  input  wire logic power_off_request_pin_i, // power-off request pin
  input  wire logic chip_reset_pin_i,      // chip reset pin, active high
  output logic      active_ref_o,          // 0 first, 1 second reference input
  output logic      holdover_o,            // device in holdover
  output logic      powered_down_o,        // full power-down state
  output logic      core_reset_o           // reset to the rest of the device
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [ref_select_pkg::PIN_COUNT-1:0] pins_sync;
  logic       ref_pin_s;
  logic       hold_pin_s;
  logic       pwroff_s;
  logic       chip_rst_s;

  pin_sync #(.WIDTH(ref_select_pkg::PIN_COUNT)) u_sync (
    .clk_i   (core_clk_i),
    .rst_i   (rst_i),
    .async_i ({chip_reset_pin_i, power_off_request_pin_i, holdover_pin_i, reference_choice_pin_i}),
    .sync_o  (pins_sync)
  );
  assign ref_pin_s  = pins_sync[ref_select_pkg::PIN_IDX_REF];
  assign hold_pin_s = pins_sync[ref_select_pkg::PIN_IDX_HOLD];
  assign pwroff_s   = pins_sync[ref_select_pkg::PIN_IDX_PWROFF];
  assign chip_rst_s = pins_sync[ref_select_pkg::PIN_IDX_RST];

  // logic reset while either reset source is high
  logic blk_rst;
  assign blk_rst = rst_i | chip_rst_s;

  // ---------------------------------------------------------------
  // operating state
  // ---------------------------------------------------------------
  ref_select_pkg::op_state_e state_reg;
  ref_select_pkg::op_state_e state_next;

  always_comb begin
    case (state_reg)
      ref_select_pkg::ST_RESET:    state_next = pwroff_s ? ref_select_pkg::ST_POWEROFF : ref_select_pkg::ST_RUN;
      ref_select_pkg::ST_RUN:      state_next = pwroff_s ? ref_select_pkg::ST_POWEROFF : ref_select_pkg::ST_RUN;
      ref_select_pkg::ST_POWEROFF: state_next = pwroff_s ? ref_select_pkg::ST_POWEROFF : ref_select_pkg::ST_RUN;
      default:                     state_next = ref_select_pkg::ST_RESET;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (blk_rst) begin
      state_reg <= ref_select_pkg::ST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  logic running;
  assign running = (state_reg == ref_select_pkg::ST_RUN);

  // ---------------------------------------------------------------
  // reference choice
  // ---------------------------------------------------------------
  // pin or switchover level to reference index; low is the first input
  function automatic logic level_to_ref(input logic level);
    return level ? ref_select_pkg::REF_SECOND : ref_select_pkg::REF_FIRST;
  endfunction

  always_ff @(posedge core_clk_i) begin
    if (blk_rst) begin
      active_ref_o              <= ref_select_pkg::REF_FIRST;
      reference_choice_pin_o    <= ref_select_pkg::PIN_RESET_VAL;
      reference_choice_pin_oe_o <= ref_select_pkg::DRIVE_OFF;
    end else if (ref_auto_mode_i && running) begin
      active_ref_o              <= level_to_ref(auto_ref_choice_i);
      reference_choice_pin_o    <= auto_ref_choice_i;
      reference_choice_pin_oe_o <= ref_select_pkg::DRIVE_ON;
    end else begin
      active_ref_o              <= level_to_ref(ref_pin_s);
      reference_choice_pin_o    <= ref_select_pkg::PIN_RESET_VAL;
      reference_choice_pin_oe_o <= ref_select_pkg::DRIVE_OFF;
    end
  end

  // ---------------------------------------------------------------
  // holdover
  // ---------------------------------------------------------------
  logic hold_now;
  assign hold_now = hold_auto_mode_i ? auto_holdover_i : hold_pin_s;

  always_ff @(posedge core_clk_i) begin
    if (blk_rst) begin
      holdover_o        <= ref_select_pkg::HOLD_OFF;
      holdover_pin_o    <= ref_select_pkg::HOLD_OFF;
      holdover_pin_oe_o <= ref_select_pkg::DRIVE_OFF;
    end else begin
      holdover_o        <= running & hold_now;
      holdover_pin_o    <= hold_auto_mode_i & running & auto_holdover_i;
      holdover_pin_oe_o <= hold_auto_mode_i & running;
    end
  end

  // ---------------------------------------------------------------
  // power-down and reset outputs
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (blk_rst) begin
      powered_down_o <= ref_select_pkg::PDN_IDLE;
      core_reset_o   <= ref_select_pkg::CORE_RST_ON;
    end else begin
      powered_down_o <= (state_next == ref_select_pkg::ST_POWEROFF);
      core_reset_o   <= ref_select_pkg::CORE_RST_OFF;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // power-off request held on two edges in a row outside reset
  sequence s_pwroff_held;
    (pwroff_s && !blk_rst) [*2];
  endsequence

  // power-off request gone on two edges in a row
  sequence s_pwroff_gone;
    !pwroff_s [*2];
  endsequence

  // raw pin rising outside reset and still high one edge later
  sequence s_rst_pin_rise;
    (!rst_i && $rose(chip_reset_pin_i)) ##1 chip_reset_pin_i;
  endsequence

  sequence s_hold_pin_rise;
    (!rst_i && $rose(holdover_pin_i)) ##1 holdover_pin_i;
  endsequence

  // reset and power-down
  chk_reset_holds_core: assert property (@(posedge core_clk_i)
    chip_rst_s |=> core_reset_o)
    else $error("core reset not asserted after reset pin");
  chk_reset_pins_quiet: assert property (@(posedge core_clk_i)
    blk_rst |=> !reference_choice_pin_oe_o && !holdover_pin_oe_o && !holdover_o && !powered_down_o)
    else $error("pins driven or holdover shown during reset");
  chk_core_reset_clear: assert property (@(posedge core_clk_i)
    !blk_rst |=> !core_reset_o)
    else $error("core reset still high after release");
  chk_pwroff_enter: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    s_pwroff_held |=> powered_down_o)
    else $error("power-off request not honoured");
  chk_pwroff_leave: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    s_pwroff_gone |=> !powered_down_o)
    else $error("power-down kept without request");
  chk_down_pins_quiet: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    state_reg == ref_select_pkg::ST_POWEROFF |=> !reference_choice_pin_oe_o && !holdover_pin_oe_o && !holdover_o)
    else $error("pins driven or holdover shown while powered down");
  chk_pdn_tracks_state: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    powered_down_o == (state_reg == ref_select_pkg::ST_POWEROFF))
    else $error("power-down output differs from state");

  // reference choice pin
  chk_ref_manual_hiz: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    !ref_auto_mode_i |=> !reference_choice_pin_oe_o)
    else $error("reference pin driven in manual mode");
  chk_ref_manual_follow: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    !blk_rst && !ref_auto_mode_i |=> active_ref_o == $past(ref_pin_s))
    else $error("active reference does not follow pin");
  chk_ref_auto_drive: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    ref_auto_mode_i && running |=> reference_choice_pin_oe_o && reference_choice_pin_o == $past(auto_ref_choice_i))
    else $error("reference pin not reporting active reference");
  chk_ref_pin_matches: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    reference_choice_pin_oe_o |-> reference_choice_pin_o == active_ref_o)
    else $error("reported reference differs from active one");
  chk_ref_auto_oe_off: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    !(ref_auto_mode_i && running) |=> !reference_choice_pin_oe_o)
    else $error("reference pin driven outside automatic run");

  // holdover pin
  chk_hold_manual_in: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    !hold_auto_mode_i && running && hold_pin_s |=> holdover_o && !holdover_pin_oe_o)
    else $error("manual holdover not entered");
  chk_hold_manual_out: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    !hold_auto_mode_i && running && !hold_pin_s |=> !holdover_o)
    else $error("holdover shown without pin request");
  chk_hold_auto_out: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    hold_auto_mode_i && running |=> holdover_pin_oe_o && holdover_pin_o == holdover_o)
    else $error("holdover pin does not report holdover");
  chk_hold_auto_level: assert property (@(posedge core_clk_i) disable iff (blk_rst)
    hold_auto_mode_i && running |=> holdover_pin_o == $past(auto_holdover_i))
    else $error("holdover pin level differs from demand");

  // synchronisers
  chk_sync_delay: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_rst_pin_rise |=> chip_rst_s)
    else $error("reset pin not synchronised in two cycles");
  chk_hold_sync_delay: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_hold_pin_rise |=> hold_pin_s)
    else $error("holdover pin not synchronised in two cycles");
endmodule
`default_nettype wire

//--- bench/ctrl_partner.sv
// system controller model on the reference choice and holdover pins
// assumes the bench sets its drive enables and levels at the core clock edge
`timescale 1ns/10ps
`default_nettype none
module ctrl_partner (
  input  wire logic clk_i,        // core clock
  input  wire logic ref_drive_i,  // controller drives reference choice pin
  input  wire logic ref_val_i,    // controller level on reference choice pin
  input  wire logic hold_drive_i, // controller drives holdover pin
  input  wire logic hold_val_i,   // controller level on holdover pin
  input  wire logic ref_dev_i,    // device level on reference choice pin
  input  wire logic ref_dev_oe_i, // device drives reference choice pin
  input  wire logic hold_dev_i,   // device level on holdover pin
  input  wire logic hold_dev_oe_i,// device drives holdover pin
  output logic      ref_wire_o,   // resolved reference choice pin
  output logic      hold_wire_o   // resolved holdover pin
);
  logic ref_last_reg  = 1'h0;
  logic hold_last_reg = 1'h0;
  // remember only levels that someone actually drove, so a released pin shows the inverse of that level
  always_ff @(posedge clk_i) begin
    if (ref_dev_oe_i || ref_drive_i) begin
      ref_last_reg <= ref_wire_o;
    end
    if (hold_dev_oe_i || hold_drive_i) begin
      hold_last_reg <= hold_wire_o;
    end
  end
  // no pull on either pin: an undriven wire shows the inverse of its last driven level
  always_comb begin
    ref_wire_o  = ref_dev_oe_i ? ref_dev_i : (ref_drive_i ? ref_val_i : ~ref_last_reg);
    hold_wire_o = hold_dev_oe_i ? hold_dev_i : (hold_drive_i ? hold_val_i : ~hold_last_reg);
  end
endmodule
`default_nettype wire

//--- bench/ref_select_holdover_pins_bench.sv
// self-checking bench for the reference choice / holdover pin block
// assumes the partner model resolves the two-way pins
`timescale 1ns/10ps
`default_nettype none
module ref_select_holdover_pins_bench;
  logic core_clk_i = 0, rst_i = 1, ref_auto = 0, hold_auto = 0, auto_ref = 0, auto_hold = 0;
  logic ref_drv = 1, ref_val = 0, hold_drv = 1, hold_val = 0, pwr_off = 0, chip_rst = 1;
  logic ref_wire, hold_wire, ref_o, ref_oe, hold_o, hold_oe, act_ref, hold_st, pdn, crst;
  int miscompares = 0, n_checks = 0, cycles = 0;
  initial forever #2 core_clk_i = ~core_clk_i;
  ctrl_partner u_ctl (.clk_i(core_clk_i), .ref_drive_i(ref_drv), .ref_val_i(ref_val), .hold_drive_i(hold_drv),
    .hold_val_i(hold_val), .ref_dev_i(ref_o), .ref_dev_oe_i(ref_oe), .hold_dev_i(hold_o),
    .hold_dev_oe_i(hold_oe), .ref_wire_o(ref_wire), .hold_wire_o(hold_wire));
  ref_select_holdover_pins u_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ref_auto_mode_i(ref_auto),
    .hold_auto_mode_i(hold_auto), .auto_ref_choice_i(auto_ref), .auto_holdover_i(auto_hold),
    .reference_choice_pin_i(ref_wire), .reference_choice_pin_o(ref_o), .reference_choice_pin_oe_o(ref_oe),
    .holdover_pin_i(hold_wire), .holdover_pin_o(hold_o), .holdover_pin_oe_o(hold_oe),
    .power_off_request_pin_i(pwr_off), .chip_reset_pin_i(chip_rst), .active_ref_o(act_ref),
    .holdover_o(hold_st), .powered_down_o(pdn), .core_reset_o(crst));
  task automatic check(input logic seen, input logic exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic manual_ref;
    @(posedge core_clk_i) ref_val <= ref_select_pkg::REF_SECOND;
    step(4);
    check(act_ref, 1'h1, "manual high pin");
    check(ref_oe, 1'h0, "manual pin driven");
    @(posedge core_clk_i) ref_val <= ref_select_pkg::REF_FIRST;
    step(4);
    check(act_ref, 1'h0, "manual low pin");
  endtask
  task automatic auto_ref_drive;
    @(posedge core_clk_i) begin ref_drv <= 0; ref_auto <= 1; auto_ref <= 1; end
    step(2);
    check(ref_oe, 1'h1, "auto pin not driven");
    check(ref_wire, 1'h1, "auto pin level second");
    @(posedge core_clk_i) auto_ref <= 0;
    step(2);
    check(ref_wire, 1'h0, "auto pin level first");
    check(act_ref, 1'h0, "auto active ref");
    @(posedge core_clk_i) ref_auto <= 0;
    @(posedge core_clk_i) ref_drv <= 1;
  endtask
  task automatic holdover_modes;
    @(posedge core_clk_i) hold_val <= 1;
    step(1);
    check(hold_st, 1'h0, "holdover seen before sync");
    step(3);
    check(hold_st, 1'h1, "manual holdover");
    @(posedge core_clk_i) begin hold_drv <= 0; hold_auto <= 1; auto_hold <= 1; end
    step(2);
    check(hold_oe, 1'h1, "auto holdover not driven");
    check(hold_wire, 1'h1, "auto holdover level");
    @(posedge core_clk_i) auto_hold <= 0;
    step(2);
    check(hold_wire, 1'h0, "auto holdover idle");
  endtask
  task automatic power_off;
    @(posedge core_clk_i) begin auto_hold <= 1; pwr_off <= 1; end
    step(5);
    check(pdn, 1'h1, "power-down missing");
    check(hold_st, 1'h0, "holdover while down");
    @(posedge core_clk_i) pwr_off <= 0;
    step(5);
    check(pdn, 1'h0, "power-down stuck");
  endtask
  task automatic chip_reset;
    @(posedge core_clk_i) chip_rst <= 1;
    step(1);
    check(crst, 1'h0, "reset pin unsynchronised");
    step(4);
    check(crst, 1'h1, "core reset missing");
    check(hold_oe, 1'h0, "pin driven in reset");
    check(hold_st, 1'h0, "holdover in reset");
    @(posedge core_clk_i) chip_rst <= 0;
    step(5);
    check(crst, 1'h0, "core reset stuck");
  endtask
  initial begin
    step(16);
    @(posedge core_clk_i) begin rst_i <= 0; chip_rst <= 0; end
    step(5);
    check(crst, 1'h0, "still in reset");
    manual_ref();
    auto_ref_drive();
    holdover_modes();
    power_off();
    chip_reset();
    summarize();
  end
endmodule
`default_nettype wire
